// ==== stp_cfg.svh ====
// register offsets, field positions, reset values and counts for the timer block
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
`define STP_OFF_CTRL 4'h0
`define STP_OFF_COUNT_L 4'h1
`define STP_OFF_COUNT_H 4'h2
`define STP_OFF_CMPA_L 4'h3
`define STP_OFF_CMPA_H 4'h4
`define STP_OFF_CMPB_L 4'h5
`define STP_OFF_CMPB_H 4'h6
`define STP_OFF_CAP_L 4'h7
`define STP_OFF_CAP_H 4'h8
`define STP_OFF_MASK 4'h9
`define STP_OFF_FLAGS 4'hA
`define STP_CTRL_MODE_LSB 0
`define STP_CTRL_COMA_LSB 4
`define STP_CTRL_COMB_LSB 6
`define STP_CTRL_PRE_LSB 8
`define STP_CTRL_GATE_BIT 11
`define STP_CTRL_DIRA_BIT 12
`define STP_CTRL_DIRB_BIT 13
`define STP_CTRL_CAPSRC_BIT 14
`define STP_CTRL_RESET 16'h0800
`define STP_BIT_OVF 0
`define STP_BIT_CMPA 1
`define STP_BIT_CMPB 2
`define STP_BIT_CAP 5
`define STP_MASK_USED 8'h27
`define STP_MAX 16'hFFFF
`define STP_BOTTOM 16'h0000
`define STP_TOP_8 16'h00FF
`define STP_TOP_9 16'h01FF
`define STP_TOP_10 16'h03FF
`define STP_DIV_8 10'h007
`define STP_DIV_64 10'h03F
`define STP_DIV_256 10'h0FF
`define STP_DIV_1024 10'h3FF
`endif

// ==== stp_pkg.sv ====
// types shared by the timer block
package stp_pkg;
  typedef enum logic [3:0] {
    STP_NORMAL = 4'b0000,
    STP_FAST8 = 4'b0101,
    STP_FAST9 = 4'b0110,
    STP_FAST10 = 4'b0111,
    STP_CTC_A = 4'b0100,
    STP_CTC_CAP = 4'b1100,
    STP_FAST_CAP = 4'b1110,
    STP_FAST_A = 4'b1111
  } stp_mode_type;

  typedef enum logic [1:0] {
    STP_BUS_IDLE = 2'b00,
    STP_BUS_DONE = 2'b01
  } stp_bus_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] cmpa;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb;
    logic [15:0] cmpb_buf;
    logic [15:0] capture;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] temp;
    logic [9:0] pre;
    logic outa;
    logic outb;
    logic [1:0] cap_sync;
    logic cap_last;
    logic [1:0] cmp_sync;
    logic cmp_last;
    stp_bus_type bus;
    logic [31:0] rdata;
  } stp_state_type;
endpackage : stp_pkg

// ==== stp_timer.sv ====
// 16-bit timer with clear-on-match, fast pwm, input capture and avalon register access
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "stp_cfg.svh"

module stp_timer #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic global_irq_enable,
  output logic compare_a_output,
  output logic compare_a_output_en,
  output logic compare_b_output,
  output logic compare_b_output_en,
  output logic capture_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic overflow_irq
);

  stp_pkg::stp_state_type q;
  stp_pkg::stp_state_type d;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic is_fast(input logic [3:0] m);
    case (m)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
        is_fast = 1'b1;
      end
      default: begin
        is_fast = 1'b0;
      end
    endcase
  endfunction : is_fast

  function automatic logic is_ctc(input logic [3:0] m);
    case (m)
      4'h4, 4'hC: begin
        is_ctc = 1'b1;
      end
      default: begin
        is_ctc = 1'b0;
      end
    endcase
  endfunction : is_ctc

  // while capture defines top the pin capture is held off, so only a software write to the capture register can move top under the counter
  function automatic logic cap_is_top(input logic [3:0] m);
    case (m)
      4'hC, 4'hE: begin
        cap_is_top = 1'b1;
      end
      default: begin
        cap_is_top = 1'b0;
      end
    endcase
  endfunction : cap_is_top

  // counter top for the selected waveform mode; unused codes count the full range
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp, input logic [15:0] cap);
    logic [15:0] t;
    t = `STP_MAX;
    case (m)
      4'h5: begin
        t = `STP_TOP_8;
      end
      4'h6: begin
        t = `STP_TOP_9;
      end
      4'h7: begin
        t = `STP_TOP_10;
      end
      4'h4: begin
        t = cmp;
      end
      4'hF: begin
        t = cmp;
      end
      4'hC: begin
        t = cap;
      end
      4'hE: begin
        t = cap;
      end
      default: begin
        t = `STP_MAX;
      end
    endcase
    top_of = t;
  endfunction : top_of

  // prescaler end count; select 1 leaves zero, so the counter ticks every clock
  function automatic logic [9:0] div_of(input logic [2:0] sel);
    logic [9:0] v;
    case (sel)
      3'h2: begin
        v = `STP_DIV_8;
      end
      3'h3: begin
        v = `STP_DIV_64;
      end
      3'h4: begin
        v = `STP_DIV_256;
      end
      3'h5: begin
        v = `STP_DIV_1024;
      end
      default: begin
        v = 10'h000;
      end
    endcase
    div_of = v;
  endfunction : div_of

  // read byte of one register index; loading temp from the low byte is left to the caller
  function automatic logic [7:0] rd_byte(input logic [3:0] a, input stp_pkg::stp_state_type s);
    logic [7:0] r;
    case (a)
      `STP_OFF_COUNT_L: begin
        r = s.count[7:0];
      end
      `STP_OFF_CMPA_L: begin
        r = s.cmpa_buf[7:0];
      end
      `STP_OFF_CMPB_L: begin
        r = s.cmpb_buf[7:0];
      end
      `STP_OFF_CAP_L: begin
        r = s.capture[7:0];
      end
      `STP_OFF_COUNT_H, `STP_OFF_CAP_H: begin
        r = s.temp;
      end
      `STP_OFF_CMPA_H: begin
        r = s.cmpa_buf[15:8];
      end
      `STP_OFF_CMPB_H: begin
        r = s.cmpb_buf[15:8];
      end
      `STP_OFF_MASK: begin
        r = s.mask;
      end
      `STP_OFF_FLAGS: begin
        r = s.flags;
      end
      default: begin
        r = 8'h00;
      end
    endcase
    rd_byte = r;
  endfunction : rd_byte

  // write-one-to-clear; a flag raised in the same cycle survives the clear
  function automatic logic [7:0] clear_flags(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
    logic [7:0] r;
    r = cur & ~(clr & `STP_MASK_USED);
    r = r | set;
    clear_flags = r;
  endfunction : clear_flags

  // an interrupt line needs its flag, its own enable and the global enable
  function automatic logic irq_of(input logic gie, input logic en, input logic flag);
    irq_of = gie & en & flag;
  endfunction : irq_of

  // compare output action: set / clear / toggle against the mode bits
  function automatic logic wave_step(input logic cur, input logic [1:0] com, input logic fast,
                                     input logic match, input logic at_top);
    logic r;
    r = cur;
    if (fast) begin
      if (com == 2'h2) begin
        if (match) r = 1'b1;
        if (at_top) r = 1'b0;
      end else if (com == 2'h3) begin
        if (match) r = 1'b0;
        if (at_top) r = 1'b1;
      end else if (com == 2'h1 && match) begin
        r = ~cur;
      end
    end else if (match) begin
      case (com)
        2'h1: r = ~cur;
        2'h2: r = 1'b0;
        2'h3: r = 1'b1;
        default: r = cur;
      endcase
    end
    wave_step = r;
  endfunction : wave_step

  logic [3:0] mode;
  logic [1:0] coma;
  logic [1:0] comb;
  logic [2:0] presel;
  logic gated;
  logic fast;
  logic clear_on_match_mode;
  logic [15:0] top;
  logic tick;
  logic at_top;
  logic match_a;
  logic match_b;
  logic cap_edge;
  logic cap_in;
  logic [15:0] wd16;
  logic [7:0] wb;
  logic [7:0] rb;
  logic [9:0] div_lim;

  always_comb begin
    mode = q.ctrl[`STP_CTRL_MODE_LSB +: 4];
    coma = q.ctrl[`STP_CTRL_COMA_LSB +: 2];
    comb = q.ctrl[`STP_CTRL_COMB_LSB +: 2];
    presel = q.ctrl[`STP_CTRL_PRE_LSB +: 3];
    gated = q.ctrl[`STP_CTRL_GATE_BIT];
    fast = is_fast(mode);
    clear_on_match_mode = is_ctc(mode);
    // ctc top is read straight from the register: a write below the count misses the match
    top = top_of(mode, q.cmpa, q.capture);
    div_lim = div_of(presel);
    // presel 0 stops the counter; 1 runs at the full clock
    tick = !gated && (presel != 3'h0) && (presel < 3'h6) && (q.pre == div_lim);
    at_top = (q.count == top);
    match_a = (q.count == q.cmpa);
    match_b = (q.count == q.cmpb);
    cap_in = q.ctrl[`STP_CTRL_CAPSRC_BIT] ? q.cmp_sync[1] : q.cap_sync[1];
    cap_edge = cap_in & ~(q.ctrl[`STP_CTRL_CAPSRC_BIT] ? q.cmp_last : q.cap_last);
    wd16 = {q.temp, avs_writedata[7:0]};
    wb = avs_writedata[7:0];
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    // synchronisers: first stage read only by the second
    d.cap_sync = {q.cap_sync[0], capture_pin};
    d.cmp_sync = {q.cmp_sync[0], comparator_out};
    d.cap_last = q.cap_sync[1];
    d.cmp_last = q.cmp_sync[1];
    d.pre = (gated || tick || presel == 3'h0) ? 10'h000 : q.pre + 10'h001;
    if (tick) begin
      if (fast || clear_on_match_mode) begin
        if (at_top) begin
          d.count = `STP_BOTTOM;
          if (fast) begin
            d.cmpa = q.cmpa_buf;
            d.cmpb = q.cmpb_buf;
            d.flags[`STP_BIT_OVF] = 1'b1;
          end
          if (cap_is_top(mode)) d.flags[`STP_BIT_CAP] = 1'b1;
        end else begin
          d.count = q.count + 16'h0001;
        end
      end else begin
        d.count = q.count + 16'h0001;
      end
      if (q.count == `STP_MAX) d.flags[`STP_BIT_OVF] = 1'b1;
      if (match_a) d.flags[`STP_BIT_CMPA] = 1'b1;
      if (match_b) d.flags[`STP_BIT_CMPB] = 1'b1;
      d.outa = wave_step(q.outa, coma, fast, match_a, at_top && fast);
      d.outb = wave_step(q.outb, comb, fast, match_b, at_top && fast);
    end
    rb = 8'h00;
    d.bus = stp_pkg::STP_BUS_IDLE;
    if ((avs_read || avs_write) && q.bus == stp_pkg::STP_BUS_IDLE) begin
      d.bus = stp_pkg::STP_BUS_DONE;
      if (avs_write) begin
        // flags clear by writing one; a same-cycle counter set wins only for a flag that was clear before the write, a pin capture always wins
        case (avs_address)
          `STP_OFF_CTRL: d.ctrl = avs_writedata[15:0];
          `STP_OFF_COUNT_H, `STP_OFF_CMPA_H, `STP_OFF_CMPB_H, `STP_OFF_CAP_H: d.temp = wb;
          `STP_OFF_COUNT_L: d.count = wd16;
          `STP_OFF_CMPA_L: begin
            d.cmpa_buf = wd16;
            if (!fast) d.cmpa = wd16;
          end
          `STP_OFF_CMPB_L: begin
            d.cmpb_buf = wd16;
            if (!fast) d.cmpb = wd16;
          end
          `STP_OFF_CAP_L: d.capture = wd16;
          `STP_OFF_MASK: d.mask = wb & `STP_MASK_USED;
          `STP_OFF_FLAGS: d.flags = clear_flags(q.flags, d.flags & ~q.flags, wb);
          default: d.temp = q.temp;
        endcase
      end else begin
        rb = rd_byte(avs_address, q);
        if (avs_address == `STP_OFF_COUNT_L) d.temp = q.count[15:8];
        if (avs_address == `STP_OFF_CAP_L) d.temp = q.capture[15:8];
        if (avs_address == `STP_OFF_CTRL) d.rdata = {16'h0000, q.ctrl};
        else d.rdata = {24'h000000, rb};
      end
    end
    // capture last so it beats a same-cycle software write
    if (!gated && cap_edge && !cap_is_top(mode)) begin
      d.capture = q.count;
      d.flags[`STP_BIT_CAP] = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= `STP_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && (q.bus == stp_pkg::STP_BUS_IDLE);
    avs_readdata = q.rdata;
    // a disconnected compare unit must not show a stale wave level on its pin
    compare_a_output = q.outa & q.ctrl[`STP_CTRL_DIRA_BIT] & (coma != 2'h0);
    compare_a_output_en = q.ctrl[`STP_CTRL_DIRA_BIT] && (coma != 2'h0);
    compare_b_output = q.outb & q.ctrl[`STP_CTRL_DIRB_BIT] & (comb != 2'h0);
    compare_b_output_en = q.ctrl[`STP_CTRL_DIRB_BIT] && (comb != 2'h0);
    capture_irq = irq_of(global_irq_enable, q.mask[`STP_BIT_CAP], q.flags[`STP_BIT_CAP]);
    compare_a_irq = irq_of(global_irq_enable, q.mask[`STP_BIT_CMPA], q.flags[`STP_BIT_CMPA]);
    compare_b_irq = irq_of(global_irq_enable, q.mask[`STP_BIT_CMPB], q.flags[`STP_BIT_CMPB]);
    overflow_irq = irq_of(global_irq_enable, q.mask[`STP_BIT_OVF], q.flags[`STP_BIT_OVF]);
  end

endmodule : stp_timer

// ==== stp_timer_sva.sv ====
// port assertions for the timer block
`timescale 1ns/1ps
module stp_timer_sva #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic compare_a_output,
  input wire logic compare_a_output_en,
  input wire logic capture_irq,
  input wire logic compare_a_irq,
  input wire logic overflow_irq
);
  // ****
  // bus and pin relations
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_end_rd;
    avs_read && !avs_waitrequest;
  endsequence
  property p_wait_first;
    s_start |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_two_cycle;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("access longer than two cycles");
  property p_unmapped;
    s_end_rd and avs_address > 4'hA |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_zero;
    s_end_rd and avs_address == 4'h9 |-> avs_readdata[7:6] == 2'h0 && avs_readdata[4:3] == 2'h0;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("unused mask bits set");
  property p_cap_irq;
    capture_irq |-> global_irq_enable;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq while global off");
  property p_cmpa_irq;
    compare_a_irq |-> global_irq_enable;
  endproperty
  a_cmpa_irq: assert property (p_cmpa_irq) else $error("compare irq while global off");
  property p_ovf_irq;
    overflow_irq |-> global_irq_enable;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq while global off");
  property p_pin_dir;
    compare_a_output |-> compare_a_output_en;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("wave on pin set as input");
  property p_reset_quiet;
    $rose(rst_n) |-> !compare_a_output && !capture_irq && !overflow_irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule : stp_timer_sva

// ==== stp_pin_model.sv ====
// capture source and wave load beside the timer pins
`timescale 1ns/1ps
module stp_pin_model (
  input wire logic clk,
  input wire logic wave,
  input wire logic fire,
  output logic cap_pin,
  output int half
);
  // ****
  // pin side
  // ****
  int cnt;
  logic last;
  initial begin
    cap_pin = 1'b0;
    cnt = 0;
    last = 1'b0;
    half = 0;
  end
  // cycles between wave edges, one half period
  // sampled on the falling edge, clear of the rising edge that moves the wave
  always @(negedge clk) begin
    cnt <= cnt + 1;
    last <= wave;
    if (wave !== last) begin
      half <= cnt + 1;
      cnt <= 0;
    end
  end
  always @(posedge clk) cap_pin <= fire;
endmodule : stp_pin_model

// ==== stp_timer_tb.sv ====
// self-checking bench for the timer block
`timescale 1ns/1ps
module stp_timer_tb;
  logic clk, rst_n, rd, wr, gie, fire, capp, wreq, ao, aoe, ci;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  int n_fail, n_tests, half, seed, n, m;
  int dv[5] = '{1, 8, 64, 256, 1024};
  stp_timer dut_u (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .capture_pin(capp),
    .comparator_out(1'b0), .global_irq_enable(gie), .compare_a_output(ao), .compare_a_output_en(aoe),
    .compare_b_output(), .compare_b_output_en(), .capture_irq(ci), .compare_a_irq(), .compare_b_irq(),
    .overflow_irq());
  stp_pin_model pin_u (.clk(clk), .wave(ao), .fire(fire), .cap_pin(capp), .half(half));
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    @(posedge clk);
    if (k >= 20) n_fail++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  task report_and_stop;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ****
  // sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    seed = 62088;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    gie = 1'b0;
    fire = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 4'h0, 32'h0);
    chk(q, 32'h800);
    acc(1'b0, 4'hB, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, 4'h0, 32'h900);
    repeat (20) @(posedge clk);
    acc(1'b0, 4'h1, 32'h0);
    chk(q, 32'h0);
    m = $random(seed) & 8'hFF;
    acc(1'b1, 4'h9, m);
    acc(1'b0, 4'h9, 32'h0);
    chk(q, m & 32'h27);
    // top never drops below the count here, so no wrap to full scale
    for (int i = 0; i < 5; i++) begin
      n = i + ($random(seed) & 1);
      acc(1'b1, 4'h4, 32'h0);
      acc(1'b1, 4'h3, n);
      acc(1'b1, 4'h0, 32'h1014 | ((i + 1) << 8));
      repeat (3 * dv[i] * (n + 1) + 10) @(posedge clk);
      chk(half, dv[i] * (n + 1));
    end
    gie <= 1'b1;
    acc(1'b1, 4'h9, 32'h20);
    fire <= 1'b1;
    repeat (8) @(posedge clk);
    chk(ci, 32'h1);
    acc(1'b0, 4'h7, 32'h0);
    m = q;
    acc(1'b0, 4'h8, 32'h0);
    chk({q[7:0], m[7:0]} <= n, 32'h1);
    acc(1'b1, 4'hA, 32'h20);
    @(posedge clk);
    chk(ci, 32'h0);
    report_and_stop();
  end
endmodule : stp_timer_tb
bind stp_timer stp_timer_sva #(.CW(CW)) sva_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_enable(global_irq_enable), .compare_a_output(compare_a_output),
  .compare_a_output_en(compare_a_output_en), .capture_irq(capture_irq), .compare_a_irq(compare_a_irq),
  .overflow_irq(overflow_irq));
